// ==== include/mcd_pkg.sv ====
// constants and types for the microcontroller clock divider configuration
package mcd_pkg;
	// register indices; the avalon word address equals the index
	localparam logic [8:0] IDX_TIMER_CLOCK_CONFIG  = 9'h031;
	localparam logic [8:0] IDX_USB_OSC_LOCK_CONFIG = 9'h039;
	localparam logic [8:0] IDX_OSC_CONTROL_ZERO    = 9'h1e0;
	localparam logic [8:0] IDX_CLOCK_SELECT        = 9'h1f0;
	localparam logic [8:0] IDX_CLOCK_STATUS        = 9'h1f1;
	localparam int         MIN_ADDR_W              = 9;

	localparam logic [7:0] RST_TIMER_CLOCK_CONFIG  = 8'h0c;
	localparam logic [7:0] RST_USB_OSC_LOCK_CONFIG = 8'h00;
	localparam logic [7:0] RST_OSC_CONTROL_ZERO    = 8'h00;
	localparam logic [7:0] RST_CLOCK_SELECT        = 8'h00;

	// field positions
	localparam int CPU_SPEED_LSB   = 0;
	localparam int SLEEP_TIMER_LSB = 3;
	localparam int NO_BUZZ_BIT     = 5;
	localparam int OSC_LOCK_DIS    = 0;
	localparam int FINE_ONLY_BIT   = 1;
	localparam int ITMR_SEL_LSB    = 0;
	localparam int ITMR_DIV_LSB    = 2;
	localparam int TCAP_SEL_LSB    = 4;
	localparam int TCAP_DIV_LSB    = 6;
	localparam int CPU_EXT_BIT     = 0;
	localparam int USB_EXT_BIT     = 1;

	// divide ratios
	localparam logic [7:0] CPU_DIV_SAFE     = 8'h08;
	localparam int         WDOG_SLEEP_TICKS = 3;

	typedef enum logic [1:0] {
		MCD_SRC_OSC24,
		MCD_SRC_EXT,
		MCD_SRC_OSC32K,
		MCD_SRC_ALT
	} mcd_src_t;
endpackage

// ==== hw/mcd_clock_config.sv ====
// clock configuration block: dividers, oscillator lock control, avalon regs
`timescale 1ns/10ps
`default_nettype none

module mcd_tick_div #(
	parameter int W = 8
) (
	input  wire logic         core_clk_i,
	input  wire logic         arst_n_i,
	input  wire logic         tick_i,
	input  wire logic [W-1:0] ratio_i,
	output logic              pulse_o
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_pulse;
	// a ratio shrunk below the running count ends the period at once
	always_comb begin
		next_cnt   = cnt;
		next_pulse = 1'b0;
		if (tick_i) begin
			if (cnt >= ratio_i - W'(1)) begin
				next_cnt   = '0;
				next_pulse = 1'b1;
			end else begin
				next_cnt = cnt + W'(1);
			end
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt     <= '0;
			pulse_o <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			pulse_o <= next_pulse;
		end
	end
endmodule // mcd_tick_div

module mcd_clock_config #(
	parameter int ADDR_W = 9
) (
	input  wire logic              core_clk_i,
	input  wire logic              arst_n_i,
	input  wire logic [ADDR_W-1:0] address_i,
	input  wire logic              read_i,
	input  wire logic              write_i,
	input  wire logic [3:0]        byteenable_i,
	input  wire logic [31:0]       writedata_i,
	output logic      [31:0]       readdata_o,
	output logic                   waitrequest_o,
	input  wire logic              osc24_tick_i,
	input  wire logic              external_clock_input_i,
	input  wire logic              osc32k_tick_i,
	input  wire logic              sleep_ref_tick_i,
	input  wire logic              in_sleep_i,
	input  wire logic              usb_packet_i,
	output logic                   processor_clock_o,
	output logic                   capture_timer_clock_o,
	output logic                   interval_timer_clock_o,
	output logic                   sleep_tick_o,
	output logic                   watchdog_tick_o,
	output logic                   no_buzz_o,
	output logic                   usb_clk_external_o,
	output logic                   trim_enable_o,
	output logic                   coarse_enable_o,
	output logic                   trim_update_o
);
	import mcd_pkg::*;
	if (ADDR_W < MIN_ADDR_W) begin : g_bad_addr_w
		$error("ADDR_W too narrow for the register map");
	end
	logic [7:0] osc_control_zero;
	logic [7:0] timer_clock_config;
	logic [7:0] usb_osc_lock_config;
	logic [7:0] clock_select;
	logic [7:0] next_osc_control_zero;
	logic [7:0] next_timer_clock_config;
	logic [7:0] next_usb_osc_lock_config;
	logic [7:0] next_clock_select;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic [8:0]  idx;
	logic        req;
	logic        wr_done;
	assign idx     = address_i[8:0];
	assign req     = read_i | write_i;
	// a write lands at the edge where the master sees waitrequest low
	assign wr_done = write_i & ~waitrequest_o & byteenable_i[0];
	always_comb begin
		next_osc_control_zero    = osc_control_zero;
		next_timer_clock_config  = timer_clock_config;
		next_usb_osc_lock_config = usb_osc_lock_config;
		next_clock_select        = clock_select;
		next_readdata            = readdata_o;
		next_waitrequest         = 1'b1;
		if (req && waitrequest_o) begin // one wait state, then low once
			next_waitrequest = 1'b0;
			case (idx)
				IDX_OSC_CONTROL_ZERO:
					next_readdata = {24'h0, osc_control_zero};
				IDX_TIMER_CLOCK_CONFIG:
					next_readdata = {24'h0, timer_clock_config};
				IDX_USB_OSC_LOCK_CONFIG:
					next_readdata = {24'h0, usb_osc_lock_config};
				IDX_CLOCK_SELECT:
					next_readdata = {24'h0, clock_select};
				IDX_CLOCK_STATUS:
					next_readdata = {29'h0, clock_select[CPU_EXT_BIT],
						coarse_enable_o, trim_enable_o};
				default:
					next_readdata = 32'h0;
			endcase
		end
		if (wr_done) begin
			case (idx)
				IDX_OSC_CONTROL_ZERO:
					next_osc_control_zero = {2'h0, writedata_i[5:0]};
				IDX_TIMER_CLOCK_CONFIG:
					next_timer_clock_config = writedata_i[7:0];
				IDX_USB_OSC_LOCK_CONFIG:
					next_usb_osc_lock_config = {6'h0, writedata_i[1:0]};
				IDX_CLOCK_SELECT:
					next_clock_select = {6'h0, writedata_i[1:0]};
				default: ;
			endcase
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			osc_control_zero    <= RST_OSC_CONTROL_ZERO;
			timer_clock_config  <= RST_TIMER_CLOCK_CONFIG;
			usb_osc_lock_config <= RST_USB_OSC_LOCK_CONFIG;
			clock_select        <= RST_CLOCK_SELECT;
			readdata_o          <= 32'h0;
			waitrequest_o       <= 1'b1;
		end else begin
			osc_control_zero    <= next_osc_control_zero;
			timer_clock_config  <= next_timer_clock_config;
			usb_osc_lock_config <= next_usb_osc_lock_config;
			clock_select        <= next_clock_select;
			readdata_o          <= next_readdata;
			waitrequest_o       <= next_waitrequest;
		end
	end
	logic [2:0] cpu_speed;
	logic [1:0] sleep_code;
	mcd_src_t   tcap_sel;
	mcd_src_t   itmr_sel;
	logic [1:0] tcap_div;
	logic [1:0] itmr_div;
	assign cpu_speed  = osc_control_zero[CPU_SPEED_LSB +: 3];
	assign sleep_code = osc_control_zero[SLEEP_TIMER_LSB +: 2];
	assign tcap_sel   = mcd_src_t'(timer_clock_config[TCAP_SEL_LSB +: 2]);
	assign itmr_sel   = mcd_src_t'(timer_clock_config[ITMR_SEL_LSB +: 2]);
	assign tcap_div   = timer_clock_config[TCAP_DIV_LSB +: 2];
	assign itmr_div   = timer_clock_config[ITMR_DIV_LSB +: 2];
	logic [7:0] cpu_ratio;
	logic [3:0] tcap_ratio;
	logic [2:0] itmr_ratio;
	logic [9:0] sleep_ratio;
	logic       cpu_src;
	logic       tcap_src;
	logic       itmr_src;
	logic       osc32k_ok;
	// the 32 kHz oscillator is not a usable source during sleep
	assign osc32k_ok = osc32k_tick_i & ~in_sleep_i;
	always_comb begin
		// same ratio table for either cpu source
		case (cpu_speed)
			3'h0:    cpu_ratio = 8'h08;
			3'h1:    cpu_ratio = 8'h04;
			3'h2:    cpu_ratio = 8'h02;
			3'h3:    cpu_ratio = 8'h01;
			3'h4:    cpu_ratio = 8'h10;
			3'h5:    cpu_ratio = 8'h20;
			3'h6:    cpu_ratio = 8'h80;
			default: cpu_ratio = CPU_DIV_SAFE;
		endcase
		cpu_src = clock_select[CPU_EXT_BIT] ? external_clock_input_i
			: osc24_tick_i;
		case (sleep_code)
			2'h0:    sleep_ratio = 10'h001;
			2'h1:    sleep_ratio = 10'h008;
			2'h2:    sleep_ratio = 10'h040;
			default: sleep_ratio = 10'h200;
		endcase
		tcap_ratio = {tcap_div, 1'b0} + 4'h2;
		itmr_ratio = {1'b0, itmr_div} + 3'h1;
		case (tcap_sel)
			MCD_SRC_OSC24:  tcap_src = osc24_tick_i;
			MCD_SRC_EXT:    tcap_src = external_clock_input_i;
			MCD_SRC_OSC32K: tcap_src = osc32k_ok;
			default:        tcap_src = 1'b0;
		endcase
		case (itmr_sel)
			MCD_SRC_OSC24:  itmr_src = osc24_tick_i;
			MCD_SRC_EXT:    itmr_src = external_clock_input_i;
			MCD_SRC_OSC32K: itmr_src = osc32k_ok;
			default:        itmr_src = capture_timer_clock_o;
		endcase
	end

	mcd_tick_div #(.W(8)) u_cpu_div (.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i), .tick_i(cpu_src), .ratio_i(cpu_ratio),
		.pulse_o(processor_clock_o));
	mcd_tick_div #(.W(4)) u_tcap_div (.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i), .tick_i(tcap_src), .ratio_i(tcap_ratio),
		.pulse_o(capture_timer_clock_o));
	mcd_tick_div #(.W(3)) u_itmr_div (.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i), .tick_i(itmr_src), .ratio_i(itmr_ratio),
		.pulse_o(interval_timer_clock_o));
	mcd_tick_div #(.W(10)) u_sleep_div (.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i), .tick_i(sleep_ref_tick_i),
		.ratio_i(sleep_ratio), .pulse_o(sleep_tick_o));
	// watchdog period spans three sleep periods
	logic [1:0] wdog_cnt;
	logic [1:0] next_wdog_cnt;
	logic       next_watchdog_tick;
	logic       next_trim_enable;
	logic       next_coarse_enable;
	logic       next_trim_update;
	always_comb begin
		next_wdog_cnt      = wdog_cnt;
		next_watchdog_tick = 1'b0;
		if (sleep_ref_tick_i && (u_sleep_div.next_pulse)) begin
			if (wdog_cnt == 2'(WDOG_SLEEP_TICKS - 1)) begin
				next_wdog_cnt      = 2'h0;
				next_watchdog_tick = 1'b1;
			end else begin
				next_wdog_cnt = wdog_cnt + 2'h1;
			end
		end
		// lock runs only while the internal oscillator feeds usb
		next_trim_enable = ~usb_osc_lock_config[OSC_LOCK_DIS]
			& ~clock_select[USB_EXT_BIT];
		next_coarse_enable = next_trim_enable
			& ~usb_osc_lock_config[FINE_ONLY_BIT];
		next_trim_update = usb_packet_i & next_trim_enable;
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wdog_cnt           <= 2'h0;
			watchdog_tick_o    <= 1'b0;
			trim_enable_o      <= 1'b0;
			coarse_enable_o    <= 1'b0;
			trim_update_o      <= 1'b0;
			no_buzz_o          <= 1'b0;
			usb_clk_external_o <= 1'b0;
		end else begin
			wdog_cnt           <= next_wdog_cnt;
			watchdog_tick_o    <= next_watchdog_tick;
			trim_enable_o      <= next_trim_enable;
			coarse_enable_o    <= next_coarse_enable;
			trim_update_o      <= next_trim_update;
			no_buzz_o          <= osc_control_zero[NO_BUZZ_BIT];
			usb_clk_external_o <= clock_select[USB_EXT_BIT];
		end
	end
	logic first_cycle;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			first_cycle <= 1'b1;
		end else begin
			first_cycle <= 1'b0;
		end
	end
	sequence s_cpu_tick_steady;
		cpu_src && $stable(cpu_speed) && $stable(clock_select);
	endsequence
	property p_cpu_reset;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		first_cycle |-> cpu_speed == 3'h0;
	endproperty
	a_cpu_reset: assert property (p_cpu_reset)
		else $error("cpu speed not zero after reset");
	property p_cpu_pass;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(s_cpu_tick_steady and (cpu_speed == 3'h3)) |=> processor_clock_o;
	endproperty
	a_cpu_pass: assert property (p_cpu_pass)
		else $error("undivided cpu clock missed a tick");
	property p_cpu_gap;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(processor_clock_o && cpu_speed != 3'h3 && $stable(cpu_speed))
			|=> !processor_clock_o;
	endproperty
	a_cpu_gap: assert property (p_cpu_gap)
		else $error("divided cpu clock pulsed back to back");
	property p_trim_off;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(usb_osc_lock_config[OSC_LOCK_DIS] && usb_packet_i) |=> !trim_update_o;
	endproperty
	a_trim_off: assert property (p_trim_off)
		else $error("trim update while lock disabled");
	property p_trim_src;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		clock_select[USB_EXT_BIT] |=> !trim_enable_o && !coarse_enable_o;
	endproperty
	a_trim_src: assert property (p_trim_src)
		else $error("trim active with external usb clock");
	property p_fine_only;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(usb_osc_lock_config[FINE_ONLY_BIT] && trim_enable_o)
			|=> !coarse_enable_o;
	endproperty
	a_fine_only: assert property (p_fine_only)
		else $error("coarse tuning left on in fine-only mode");
	property p_cap_off;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(tcap_sel == MCD_SRC_ALT) [*2] |-> !capture_timer_clock_o;
	endproperty
	a_cap_off: assert property (p_cap_off)
		else $error("capture clock runs while disabled");
	property p_itmr_div1;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(itmr_src && itmr_div == 2'h0 && $stable(timer_clock_config))
			|=> interval_timer_clock_o;
	endproperty
	a_itmr_div1: assert property (p_itmr_div1)
		else $error("interval clock missed a divide-by-one tick");
	property p_wdog;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		watchdog_tick_o |-> sleep_tick_o;
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("watchdog tick off the sleep tick");
	property p_bus_one_cycle;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		!waitrequest_o |=> waitrequest_o;
	endproperty
	a_bus_one_cycle: assert property (p_bus_one_cycle)
		else $error("waitrequest held low over two cycles");
endmodule // mcd_clock_config
`default_nettype wire

// ==== test/mcd_far_side.sv ====
// far-side model: tick pulses of each clock source and usb packet arrivals
`timescale 1ns/10ps
`default_nettype none

module mcd_far_side #(
	parameter int EXT_GAP = 2,
	parameter int LP_GAP  = 3,
	parameter int USB_GAP = 8
) (
	input  wire logic core_clk_i,
	output logic      osc24_tick_o,
	output logic      ext_tick_o,
	output logic      osc32k_tick_o,
	output logic      sleep_ref_tick_o,
	output logic      usb_packet_o
);
	int ce = 0;
	int cl = 0;
	int cu = 0;

	// fixed gaps so any window of whole periods holds an exact tick count
	always @(posedge core_clk_i) begin
		ce <= (ce + 1) % EXT_GAP;
		cl <= (cl + 1) % LP_GAP;
		cu <= (cu + 1) % USB_GAP;
		osc24_tick_o <= 1'b1;
		sleep_ref_tick_o <= 1'b1;
		ext_tick_o <= (ce == 0);
		osc32k_tick_o <= (cl == 0);
		// a packet every 8 core cycles, faster than the slowest cpu divide settings
		usb_packet_o <= (cu == 0);
	end
endmodule // mcd_far_side

`default_nettype wire

// ==== test/mcd_clock_config_tb.sv ====
// self-checking bench for the clock configuration block
`timescale 1ns/10ps
`default_nettype none

module mcd_clock_config_tb;
	import mcd_pkg::*;
	typedef struct {
		logic [7:0] csel;
		logic [7:0] osc;
		logic [7:0] tmr;
		logic [7:0] lock;
		logic       slp;
		int         sel;
		int         exp;
	} mcd_row_t;

	logic        core_clk_i = 1'b0;
	logic        arst_n_i   = 1'b0;
	logic [8:0]  address    = 9'h000;
	logic        read       = 1'b0;
	logic        write      = 1'b0;
	logic [3:0]  be         = 4'hf;
	logic [31:0] wdata      = 32'h00000000;
	logic        in_sleep   = 1'b0;
	logic        counting   = 1'b0;
	logic [31:0] q;
	logic [5:0]  outs;
	wire logic [31:0] readdata;
	wire logic waitrequest, osc24, ext, lp, sref, pkt, no_buzz, usb_ext;
	wire logic cpu_clk, cap_clk, int_clk, slp_tick, wdg_tick;
	wire logic trim_en, coarse_en, trim_upd;
	int bad_count = 0;
	int samples_checked = 0;
	logic [31:0] cnt = 32'h0;
	int sel = 0;
	int cpu_div[8] = '{8, 4, 2, 1, 16, 32, 128, 8};
	mcd_row_t rows[$];
	mcd_row_t r;

	assign outs = {trim_upd, wdg_tick, slp_tick, int_clk, cap_clk, cpu_clk};

	mcd_clock_config mcd_clock_config_i (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.address_i(address), .read_i(read), .write_i(write),
		.byteenable_i(be), .writedata_i(wdata), .readdata_o(readdata),
		.waitrequest_o(waitrequest), .osc24_tick_i(osc24),
		.external_clock_input_i(ext), .osc32k_tick_i(lp),
		.sleep_ref_tick_i(sref), .in_sleep_i(in_sleep),
		.usb_packet_i(pkt), .processor_clock_o(cpu_clk),
		.capture_timer_clock_o(cap_clk), .interval_timer_clock_o(int_clk),
		.sleep_tick_o(slp_tick), .watchdog_tick_o(wdg_tick),
		.no_buzz_o(no_buzz), .usb_clk_external_o(usb_ext),
		.trim_enable_o(trim_en), .coarse_enable_o(coarse_en),
		.trim_update_o(trim_upd));

	mcd_far_side mcd_far_side_i (
		.core_clk_i(core_clk_i), .osc24_tick_o(osc24), .ext_tick_o(ext),
		.osc32k_tick_o(lp), .sleep_ref_tick_o(sref), .usb_packet_o(pkt));

	always #50 core_clk_i = ~core_clk_i;

	always @(posedge core_clk_i) begin
		cnt <= counting ? cnt + {31'h0, outs[sel]} : 32'h0;
	end

	task automatic conclude();
		$display("checked=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input logic [31:0] got, input int exp);
		chk_reg(got, 32'(exp));
	endtask

	task automatic chk_lvl(input logic got, input logic exp);
		chk_reg({31'h00000000, got}, {31'h00000000, exp});
	endtask

	// one avalon access; waits for waitrequest low, no fixed latency assumed
	task automatic bus(input logic [8:0] a, input logic wr,
			input logic [7:0] d, input logic [3:0] b);
		address <= a;
		read <= !wr;
		write <= wr;
		wdata <= {24'h000000, d};
		be <= b;
		do begin
			@(posedge core_clk_i);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic rd(input logic [8:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 8'h00, 4'hf);
		chk_reg(q, exp);
	endtask

	// warm-up lets a stale divider count flush before the window opens
	task automatic measure(input int s, input int warm);
		sel <= s;
		repeat (warm) @(posedge core_clk_i);
		counting <= 1'b1;
		repeat ((s == 3 || s == 4) ? 1536 : 768) @(posedge core_clk_i);
		counting <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic add(input logic [7:0] c, o, t, l, input logic s,
			input int se, input int e);
		rows.push_back('{c, o, t, l, s, se, e});
	endtask

	initial begin
		#(100000 * 100);
		bad_count++;
		conclude();
	end

	initial begin
		for (int c = 0; c < 8; c++) begin
			add(8'h00, 8'(c), 8'h0c, 8'h00, 1'b0, 0, 768 / cpu_div[c]);
			add(8'h01, 8'(c), 8'h0c, 8'h00, 1'b0, 0, 384 / cpu_div[c]);
		end
		add(8'h00, 8'h00, 8'h0c, 8'h00, 1'b0, 1, 384);
		add(8'h00, 8'h00, 8'h4c, 8'h00, 1'b0, 1, 192);
		add(8'h00, 8'h00, 8'h8c, 8'h00, 1'b0, 1, 128);
		add(8'h00, 8'h00, 8'hcc, 8'h00, 1'b0, 1, 96);
		add(8'h00, 8'h00, 8'h9c, 8'h00, 1'b0, 1, 64);
		add(8'h00, 8'h00, 8'h2c, 8'h00, 1'b0, 1, 128);
		add(8'h00, 8'h00, 8'h2c, 8'h00, 1'b1, 1, 0);
		add(8'h00, 8'h00, 8'h3c, 8'h00, 1'b0, 1, 0);
		add(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2, 768);
		add(8'h00, 8'h00, 8'h04, 8'h00, 1'b0, 2, 384);
		add(8'h00, 8'h00, 8'h08, 8'h00, 1'b0, 2, 256);
		add(8'h00, 8'h00, 8'h0c, 8'h00, 1'b0, 2, 192);
		add(8'h00, 8'h00, 8'h01, 8'h00, 1'b0, 2, 384);
		add(8'h00, 8'h00, 8'h0e, 8'h00, 1'b0, 2, 64);
		add(8'h00, 8'h00, 8'h0b, 8'h00, 1'b0, 2, 128);
		add(8'h00, 8'h00, 8'h0c, 8'h00, 1'b0, 3, 1536);
		add(8'h00, 8'h08, 8'h0c, 8'h00, 1'b0, 3, 192);
		add(8'h00, 8'h10, 8'h0c, 8'h00, 1'b0, 3, 24);
		add(8'h00, 8'h18, 8'h0c, 8'h00, 1'b0, 3, 3);
		add(8'h00, 8'h00, 8'h0c, 8'h00, 1'b0, 4, 512);
		add(8'h00, 8'h08, 8'h0c, 8'h00, 1'b0, 4, 64);
		add(8'h00, 8'h10, 8'h0c, 8'h00, 1'b0, 4, 8);
		add(8'h00, 8'h00, 8'h0c, 8'h00, 1'b0, 5, 96);
		add(8'h00, 8'h00, 8'h0c, 8'h02, 1'b0, 5, 96);
		add(8'h00, 8'h00, 8'h0c, 8'h01, 1'b0, 5, 0);
		add(8'h02, 8'h00, 8'h0c, 8'h00, 1'b0, 5, 0);
		repeat (6) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		@(posedge core_clk_i);
		foreach (rows[i]) begin
			r = rows[i];
			bus(IDX_CLOCK_SELECT, 1'b1, r.csel, 4'hf);
			bus(IDX_OSC_CONTROL_ZERO, 1'b1, r.osc, 4'hf);
			bus(IDX_TIMER_CLOCK_CONFIG, 1'b1, r.tmr, 4'hf);
			bus(IDX_USB_OSC_LOCK_CONFIG, 1'b1, r.lock, 4'hf);
			in_sleep <= r.slp;
			measure(r.sel, 600);
			chk_cnt(cnt, r.exp);
			chk_lvl(trim_en, !r.lock[0] && !r.csel[1]);
			chk_lvl(coarse_en, !r.lock[0] && !r.csel[1] && !r.lock[1]);
			chk_lvl(usb_ext, r.csel[1]);
		end
		in_sleep <= 1'b0;
		bus(IDX_USB_OSC_LOCK_CONFIG, 1'b1, 8'hff, 4'hf);
		rd(IDX_USB_OSC_LOCK_CONFIG, 32'h00000003);
		chk_lvl(trim_en, 1'b0);
		bus(IDX_OSC_CONTROL_ZERO, 1'b1, 8'hff, 4'hf);
		rd(IDX_OSC_CONTROL_ZERO, 32'h0000003f);
		chk_lvl(no_buzz, 1'b1);
		bus(IDX_TIMER_CLOCK_CONFIG, 1'b1, 8'h55, 4'h0);
		rd(IDX_TIMER_CLOCK_CONFIG, 32'h0000000c);
		bus(9'h100, 1'b1, 8'haa, 4'hf);
		rd(9'h100, 32'h00000000);
		arst_n_i <= 1'b0;
		@(posedge core_clk_i);
		chk_lvl(waitrequest, 1'b1);
		chk_reg({26'h0, outs}, 32'h00000000);
		repeat (5) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		@(posedge core_clk_i);
		rd(IDX_OSC_CONTROL_ZERO, 32'h00000000);
		rd(IDX_TIMER_CLOCK_CONFIG, {24'h000000, RST_TIMER_CLOCK_CONFIG});
		rd(IDX_USB_OSC_LOCK_CONFIG, 32'h00000000);
		rd(IDX_CLOCK_STATUS, 32'h00000003);
		chk_lvl(no_buzz, 1'b0);
		chk_lvl(usb_ext, 1'b0);
		measure(0, 40);
		chk_cnt(cnt, 96);
		conclude();
	end
endmodule // mcd_clock_config_tb

`default_nettype wire
